//--- core/bps_pkg.sv
// power-state sequencer package: state codes, timing, carriers
// assumes a single 25 MHz standby clock
package bps_pkg;
    // ----------------------------------------------------------------
    // states
    // ----------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_MECH_OFF = 3'h0,
        ST_S0 = 3'h1,
        ST_S1 = 3'h2,
        ST_S3 = 3'h3,
        ST_S4 = 3'h4,
        ST_S5 = 3'h5
    } bps_state_e;

    // ----------------------------------------------------------------
    // timing
    // ----------------------------------------------------------------
    localparam int CLK_HZ = 25000000;
    localparam int HOLD_SEC = 4;
    localparam int HOLD_CYCLES = HOLD_SEC * CLK_HZ;
    localparam int CNT_W = 27;

    // ----------------------------------------------------------------
    // carriers
    // ----------------------------------------------------------------
    typedef struct packed {
        logic lan;
        logic pme;
        logic pme_from_lan;
        logic rtc;
        logic usb;
        logic ps2;
        logic wake_pin;
    } bps_wake_s;

    // os commands, one-cycle pulses
    typedef struct packed {
        logic go_s1;
        logic go_s3;
        logic go_s4;
        logic go_s5;
    } bps_cmd_s;
endpackage

//--- core/bps_sequencer.sv
// board power-state sequencer: power switch timing, wake gating,
// os-commanded sleep transitions
// assumes all inputs synchronous to clk; switch input already debounced
//
// Summary of operation
// - short press: off->on, on->sleep, sleep->on
// - long press from on or sleep: soft-off
// - network wakes S1,S3,S4; S5 when enabled
// - pme wakes S1,S3; S4,S5 only network
// - switch, rtc, wake pin wake any sleep
// - usb and ps2 wake only S1,S3
// - S5 network/pme wake follows s5_wake_en one cycle late, also after reset
// - S4 context on disk, cpu unpowered
// - mechanical off: no wake serviced
`timescale 1ns/1ns
module bps_sequencer #(
    parameter int HOLD_CYCLES = bps_pkg::HOLD_CYCLES
) (
    // clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // supply and configuration
    input wire logic standby_ok,
    input wire logic s5_wake_en,
    // front panel and wake sources
    input wire logic pwr_switch,
    input wire bps_pkg::bps_wake_s wake,
    // operating system commands
    input wire bps_pkg::bps_cmd_s cmd,
    // state outputs
    output bps_pkg::bps_state_e state,
    output logic main_power_on,
    output logic cpu_power_on,
    output logic restore_from_disk,
    output logic cold_boot,
    output logic wake_event
);
    // ----------------------------------------------------------------
    // wake gating
    // ----------------------------------------------------------------
    function automatic logic wake_ok(input bps_pkg::bps_state_e st,
                                     input bps_pkg::bps_wake_s w,
                                     input logic s5_en);
        logic shallow;
        logic deep;
        shallow = (st == bps_pkg::ST_S1) || (st == bps_pkg::ST_S3);
        deep = (st == bps_pkg::ST_S4) || (st == bps_pkg::ST_S5);
        wake_ok = 1'b0;
        if (shallow) begin
            wake_ok = w.lan | w.pme | w.rtc | w.wake_pin | w.usb | w.ps2;
        end else if (deep) begin
            // usb/ps2 ignored here
            wake_ok = w.rtc | w.wake_pin;
            if (st == bps_pkg::ST_S4) begin
                wake_ok = wake_ok | w.lan | (w.pme & w.pme_from_lan);
            end else if (s5_en) begin
                wake_ok = wake_ok | w.lan | (w.pme & w.pme_from_lan);
            end
        end
    endfunction

    function automatic logic is_sleep(input bps_pkg::bps_state_e st);
        is_sleep = (st == bps_pkg::ST_S1) || (st == bps_pkg::ST_S3) ||
                   (st == bps_pkg::ST_S4);
    endfunction

    // ----------------------------------------------------------------
    // switch timing and state
    // ----------------------------------------------------------------
    logic [bps_pkg::CNT_W-1:0] hold_cnt;
    logic long_done;
    logic sw_prev;
    logic s5_en;
    logic [bps_pkg::CNT_W-1:0] next_hold_cnt;
    logic next_long_done;
    bps_pkg::bps_state_e next_state;
    logic next_wake_event;
    logic next_restore;
    logic next_cold;
    logic release_short;
    logic long_fire;

    always_comb begin
        next_hold_cnt = hold_cnt;
        next_long_done = long_done;
        long_fire = 1'b0;
        release_short = 1'b0;
        if (pwr_switch) begin
            // counts while held, fires once without waiting
            if (!long_done) begin
                if (hold_cnt == bps_pkg::CNT_W'(HOLD_CYCLES - 1)) begin
                    long_fire = 1'b1;
                    next_long_done = 1'b1;
                end else begin
                    next_hold_cnt = hold_cnt + 1'b1;
                end
            end
        end else begin
            release_short = sw_prev && !long_done;
            next_hold_cnt = '0;
            next_long_done = 1'b0;
        end
    end

    always_comb begin
        next_state = state;
        next_wake_event = 1'b0;
        next_restore = 1'b0;
        next_cold = 1'b0;
        if (!standby_ok) begin
            next_state = bps_pkg::ST_MECH_OFF;
        end else begin
            case (state)
                bps_pkg::ST_MECH_OFF: begin
                    next_state = bps_pkg::ST_S5;
                end
                bps_pkg::ST_S0: begin
                    if (long_fire) begin
                        next_state = bps_pkg::ST_S5;
                    end else if (release_short) begin
                        next_state = bps_pkg::ST_S1;
                    end else if (cmd.go_s5) begin
                        next_state = bps_pkg::ST_S5;
                    end else if (cmd.go_s4) begin
                        next_state = bps_pkg::ST_S4;
                    end else if (cmd.go_s3) begin
                        next_state = bps_pkg::ST_S3;
                    end else if (cmd.go_s1) begin
                        next_state = bps_pkg::ST_S1;
                    end
                end
                bps_pkg::ST_S1, bps_pkg::ST_S3, bps_pkg::ST_S4,
                bps_pkg::ST_S5: begin
                    if (long_fire && is_sleep(state)) begin
                        next_state = bps_pkg::ST_S5;
                    end else if (release_short ||
                                 wake_ok(state, wake, s5_en)) begin
                        next_state = bps_pkg::ST_S0;
                        next_wake_event = 1'b1;
                        next_restore = (state == bps_pkg::ST_S4);
                        next_cold = (state == bps_pkg::ST_S5);
                    end
                end
                default: begin
                    next_state = bps_pkg::ST_S5;
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            hold_cnt <= '0;
            long_done <= 1'b0;
            sw_prev <= 1'b0;
            s5_en <= 1'b0;
            state <= bps_pkg::ST_MECH_OFF;
            main_power_on <= 1'b0;
            cpu_power_on <= 1'b0;
            restore_from_disk <= 1'b0;
            cold_boot <= 1'b0;
            wake_event <= 1'b0;
        end else begin
            hold_cnt <= next_hold_cnt;
            long_done <= next_long_done;
            sw_prev <= pwr_switch;
            s5_en <= s5_wake_en;
            state <= next_state;
            // S1 keeps rails but stops the cpu; S3..S5 drop both
            main_power_on <= (next_state == bps_pkg::ST_S0) ||
                             (next_state == bps_pkg::ST_S1);
            cpu_power_on <= (next_state == bps_pkg::ST_S0);
            restore_from_disk <= next_restore;
            cold_boot <= next_cold;
            wake_event <= next_wake_event;
        end
    end

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    chk_long_press_off: assert property (
        @(posedge clk) disable iff (sys_rst)
        (long_fire && standby_ok && (state == bps_pkg::ST_S0 ||
         is_sleep(state))) |=> state == bps_pkg::ST_S5)
        else $error("long press did not reach soft-off");
    chk_short_on_sleep: assert property (
        @(posedge clk) disable iff (sys_rst)
        (release_short && standby_ok && state == bps_pkg::ST_S0)
        |=> state == bps_pkg::ST_S1)
        else $error("short press in working did not sleep");
    chk_short_wake: assert property (
        @(posedge clk) disable iff (sys_rst)
        (release_short && standby_ok && state == bps_pkg::ST_S5)
        |=> state == bps_pkg::ST_S0 && cold_boot)
        else $error("short press did not power on");
    chk_usb_deep_ignored: assert property (
        @(posedge clk) disable iff (sys_rst)
        (state == bps_pkg::ST_S4 && standby_ok && !pwr_switch && !sw_prev
         && wake.usb && !wake.lan && !wake.pme && !wake.rtc
         && !wake.wake_pin) |=> state == bps_pkg::ST_S4)
        else $error("usb woke from S4");
    chk_s5_lan_gate: assert property (
        @(posedge clk) disable iff (sys_rst)
        (state == bps_pkg::ST_S5 && standby_ok && !s5_en && !sw_prev
         && !wake.rtc && !wake.wake_pin) |=> state == bps_pkg::ST_S5)
        else $error("S5 woke without enable");
    chk_s4_restore: assert property (
        @(posedge clk) disable iff (sys_rst)
        (state == bps_pkg::ST_S4 && next_state == bps_pkg::ST_S0)
        |=> restore_from_disk && cpu_power_on ##1 !restore_from_disk)
        else $error("S4 resume without restore");
    chk_rtc_wake: assert property (
        @(posedge clk) disable iff (sys_rst)
        (is_sleep(state) && standby_ok && wake.rtc && !long_fire)
        |=> wake_event && state == bps_pkg::ST_S0)
        else $error("rtc alarm did not wake");
    chk_mech_off: assert property (
        @(posedge clk) disable iff (sys_rst)
        !standby_ok |=> state == bps_pkg::ST_MECH_OFF && !wake_event
        && !main_power_on)
        else $error("activity in mechanical off");
    chk_cpu_off_sleep: assert property (
        @(posedge clk) disable iff (sys_rst)
        state != bps_pkg::ST_S0 |-> !cpu_power_on)
        else $error("cpu powered while not working");
    cov_long_press: cover property (@(posedge clk) long_fire);
    cov_s3_wake: cover property (@(posedge clk)
        state == bps_pkg::ST_S3 ##1 state == bps_pkg::ST_S0);
    cov_s5_lan: cover property (@(posedge clk)
        state == bps_pkg::ST_S5 && wake.lan && s5_en);
    cov_os_s4: cover property (@(posedge clk)
        state == bps_pkg::ST_S0 ##1 state == bps_pkg::ST_S4);
endmodule

//--- verif/bps_panel_model.sv
// front panel switch and wake source model
// assumes callers run from clk-synchronous bench code
`timescale 1ns/1ns
module bps_panel_model (
    // clock
    input wire logic clk,
    // towards the sequencer
    output logic pwr_switch,
    output bps_pkg::bps_wake_s wake
);
    initial begin
        pwr_switch = 1'h0;
        wake = '0;
    end
    // hold the switch n edges, then let go
    task automatic press(input int n);
        @(posedge clk);
        pwr_switch <= 1'h1;
        repeat (n) @(posedge clk);
        pwr_switch <= 1'h0;
    endtask
    // wake lines are levels; one sampled cycle must suffice
    task automatic pulse(input logic [6:0] w);
        @(posedge clk);
        wake <= w;
        @(posedge clk);
        wake <= '0;
    endtask
endmodule

//--- verif/tb.sv
// bench for the power-state sequencer: presses, os commands, wakes
// assumes a short hold threshold; panel model drives switch and wakes
`timescale 1ns/1ns
module tb;
    localparam int HOLD = 20;
    logic clk, sys_rst, standby_ok, s5_wake_en, pwr_switch;
    bps_pkg::bps_wake_s wake;
    bps_pkg::bps_cmd_s cmd;
    bps_pkg::bps_state_e state;
    bps_pkg::bps_state_e sts [4];
    logic main_power_on, cpu_power_on, restore_from_disk, cold_boot;
    logic wake_event;
    int err_count, n_tests, seed, i;
    int n_wake = 0, n_disk = 0, n_cold = 0;

    bps_sequencer #(.HOLD_CYCLES(HOLD)) dut (.clk(clk), .sys_rst(sys_rst),
        .standby_ok(standby_ok), .s5_wake_en(s5_wake_en),
        .pwr_switch(pwr_switch), .wake(wake), .cmd(cmd), .state(state),
        .main_power_on(main_power_on), .cpu_power_on(cpu_power_on),
        .restore_from_disk(restore_from_disk), .cold_boot(cold_boot),
        .wake_event(wake_event));
    bps_panel_model src (.clk(clk), .pwr_switch(pwr_switch), .wake(wake));

    initial begin
        clk = 1'h0;
        forever #20 clk = ~clk;
    end
    // pulses counted so checks need not hit the exact cycle
    always @(posedge clk) begin
        n_wake <= n_wake + int'(wake_event === 1'h1);
        n_disk <= n_disk + int'(restore_from_disk === 1'h1);
        n_cold <= n_cold + int'(cold_boot === 1'h1);
    end
    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    function automatic logic can_wake(bps_pkg::bps_state_e s,
                                      bps_pkg::bps_wake_s x, logic e);
        logic any, net;
        any = x.rtc | x.wake_pin;
        net = x.lan | (x.pme & x.pme_from_lan);
        case (s)
            bps_pkg::ST_S1, bps_pkg::ST_S3: can_wake = any | net | x.pme
                | x.usb | x.ps2;
            bps_pkg::ST_S4: can_wake = any | net;
            bps_pkg::ST_S5: can_wake = any | (e & net);
            default: can_wake = 1'h0;
        endcase
    endfunction
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_tests++;
        if (seen !== exp) begin
            err_count++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen,
                exp);
        end
    endtask
    task automatic expect_state(input bps_pkg::bps_state_e s);
        repeat (3) @(posedge clk);
        #1;
        check(8'(state), 8'(s));
        check({6'h0, main_power_on, cpu_power_on},
            {6'h0, s == bps_pkg::ST_S0 || s == bps_pkg::ST_S1,
            s == bps_pkg::ST_S0});
    endtask
    task automatic os_cmd(input logic [3:0] c);
        @(posedge clk);
        cmd <= c;
        @(posedge clk);
        cmd <= '0;
    endtask
    task automatic long_press();
        fork
            src.press(HOLD + 20);
            begin
                repeat (HOLD + 8) @(posedge clk);
                #1;
                check(8'(state), 8'(bps_pkg::ST_S5));
            end
        join
        expect_state(bps_pkg::ST_S5);
    endtask
    task automatic trial(input bps_pkg::bps_state_e s, input logic [6:0] x,
                         input logic e);
        int nw, nd, nc;
        logic ok;
        @(posedge clk);
        s5_wake_en <= e;
        os_cmd(4'h8 >> (s - 3'h2));
        expect_state(s);
        nw = n_wake;
        nd = n_disk;
        nc = n_cold;
        ok = can_wake(s, x, e);
        src.pulse(x);
        expect_state(ok ? bps_pkg::ST_S0 : s);
        check(8'(n_wake - nw), 8'(ok));
        check(8'(n_disk - nd), 8'(ok && s == bps_pkg::ST_S4));
        check(8'(n_cold - nc), 8'(ok && s == bps_pkg::ST_S5));
        if (!ok) begin
            // random short hold, always below the threshold
            src.press(1 + int'($unsigned($random(seed)) % 18));
            expect_state(bps_pkg::ST_S0);
        end
    endtask
    task automatic results();
        $display("errors %0d checks %0d", err_count, n_tests);
        if (err_count == 0 && n_tests > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    // ----------------------------------------------------------------
    // sequence
    // ----------------------------------------------------------------
    initial begin
        {sys_rst, standby_ok, s5_wake_en, cmd} = 7'h60;
        {err_count, n_tests} = '0;
        seed = 30;
        sts = '{bps_pkg::ST_S1, bps_pkg::ST_S3, bps_pkg::ST_S4,
            bps_pkg::ST_S5};
        repeat (12) @(posedge clk);
        sys_rst <= 1'h0;
        expect_state(bps_pkg::ST_S5);
        src.pulse(7'h40);
        expect_state(bps_pkg::ST_S5);
        src.press(3);
        expect_state(bps_pkg::ST_S0);
        src.press(15);
        expect_state(bps_pkg::ST_S1);
        long_press();
        src.press(3);
        os_cmd(4'h8);
        long_press();
        os_cmd(4'h4);
        expect_state(bps_pkg::ST_S5);
        @(posedge clk);
        standby_ok <= 1'h0;
        expect_state(bps_pkg::ST_MECH_OFF);
        src.pulse(7'h7f);
        src.press(3);
        expect_state(bps_pkg::ST_MECH_OFF);
        @(posedge clk);
        standby_ok <= 1'h1;
        expect_state(bps_pkg::ST_S5);
        src.press(3);
        expect_state(bps_pkg::ST_S0);
        for (i = 0; i < 56; i++)
            trial(sts[i % 4], 7'h1 << (i / 8), 1'((i / 4) % 2));
        repeat (40)
            trial(sts[$unsigned($random(seed)) % 4], 7'($random(seed)),
                1'($random(seed)));
        // mid-run reset from working: back through mech off to S5
        @(posedge clk);
        sys_rst <= 1'h1;
        s5_wake_en <= 1'h0;
        repeat (2) @(posedge clk);
        sys_rst <= 1'h0;
        expect_state(bps_pkg::ST_S5);
        src.pulse(7'h40);
        expect_state(bps_pkg::ST_S5);
        src.press(3);
        expect_state(bps_pkg::ST_S0);
        results();
    end
    initial begin
        repeat (30000) @(posedge clk);
        err_count++;
        results();
    end
endmodule
